// file: bfa_pkg.sv
// Package of register map, field layout and carrier types for the buffer format and accumulator registers.
package bfa_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam logic [7:0] IDX_FILL_LEVEL  = 8'h01;
  localparam logic [7:0] IDX_SUM_STATUS  = 8'h02;
  localparam logic [7:0] IDX_SUM0_LOW    = 8'h08;
  localparam logic [7:0] IDX_SUM0_HIGH   = 8'h09;
  localparam logic [7:0] IDX_SUM1_LOW    = 8'h0A;
  localparam logic [7:0] IDX_SUM1_HIGH   = 8'h0B;
  localparam logic [7:0] IDX_LAYOUT_CFG  = 8'h28;
  localparam logic [7:0] IDX_SUM_ENABLE  = 8'h30;
  localparam logic [7:0] IDX_SEQ_CTRL    = 8'h1E;
  localparam int         ADDR_SHIFT      = 2;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int         FILL_W          = 5;
  localparam int         ACC_CNT_W       = 4;
  localparam int         SUM_W           = 16;
  localparam int         RESULT_W        = 12;
  localparam int         CHID_W          = 3;
  localparam int         WORD_W          = 16;
  localparam logic [4:0] FILL_MAX        = 5'h10;
  localparam logic [3:0] ENABLE_OFF      = 4'h0;
  localparam logic [3:0] ENABLE_ON       = 4'hF;
  localparam logic [3:0] ENABLE_RESET    = 4'h0;
  localparam logic [1:0] LAYOUT_RESET    = 2'h0;
  localparam int         SEQ_LAUNCH_BIT  = 0;
  localparam int         GCALL_BIT       = 1;
  localparam int         DEVRST_BIT      = 2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    LAYOUT_PLAIN  = 2'b00,
    LAYOUT_CHID   = 2'b01,
    LAYOUT_VALID  = 2'b10,
    LAYOUT_PLAIN2 = 2'b11
  } bfa_layout_t;

  typedef struct packed {
    logic                    valid;
    logic                    channel;
    logic                    data_valid;
    logic [RESULT_W-1:0]     result;
  } bfa_conv_t;

  typedef struct packed {
    logic                    valid;
    logic [WORD_W-1:0]       word;
  } bfa_word_t;

endpackage

// file: bfa_regs.sv
// Top of the buffer format, fill count and accumulator register bank with a classic Wishbone slave.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps

module bfa_regs #(
  parameter int FILL_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Conversion results from the converter
  input  wire logic        CONV_VALID,
  input  wire logic        CONV_CHANNEL,
  input  wire logic        CONV_DATA_VALID,
  input  wire logic [11:0] CONV_RESULT,
  // Formatted word towards the data buffer
  output logic             BUF_WORD_VALID,
  output logic      [15:0] BUF_WORD,
  // Status view
  output logic      [4:0]  FILL_COUNT,
  output logic             ACC_ACTIVE
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic       req;
  logic       wr_ok;
  logic [5:0] idx;
  logic       clear_all;
  logic       launch_wr;
  logic       gcall_wr;
  logic       devrst_wr;

  assign req   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_ok = req && WB_WE_I && WB_SEL_I[0];
  assign idx   = WB_ADR_I[7:bfa_pkg::ADDR_SHIFT];

  // Pulses written into the sequence control word; software sees them read as zero.
  assign launch_wr = wr_ok && (idx == bfa_pkg::IDX_SEQ_CTRL[5:0]) && WB_DAT_I[bfa_pkg::SEQ_LAUNCH_BIT];
  assign gcall_wr  = wr_ok && (idx == bfa_pkg::IDX_SEQ_CTRL[5:0]) && WB_DAT_I[bfa_pkg::GCALL_BIT];
  assign devrst_wr = wr_ok && (idx == bfa_pkg::IDX_SEQ_CTRL[5:0]) && WB_DAT_I[bfa_pkg::DEVRST_BIT];
  assign clear_all = launch_wr || gcall_wr || devrst_wr;

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [1:0] layout_reg;
  logic [3:0] enable_reg;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      layout_reg <= bfa_pkg::LAYOUT_RESET;
    end else if (devrst_wr || gcall_wr) begin
      layout_reg <= bfa_pkg::LAYOUT_RESET;
    end else if (wr_ok && idx == bfa_pkg::IDX_LAYOUT_CFG[5:0]) begin
      layout_reg <= WB_DAT_I[1:0];
    end
  end

  // Reserved codes are stored as written but leave the accumulator off.
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      enable_reg <= bfa_pkg::ENABLE_RESET;
    end else if (devrst_wr || gcall_wr) begin
      enable_reg <= bfa_pkg::ENABLE_RESET;
    end else if (wr_ok && idx == bfa_pkg::IDX_SUM_ENABLE[5:0]) begin
      enable_reg <= WB_DAT_I[3:0];
    end
  end

  logic acc_on;
  assign acc_on = (enable_reg == bfa_pkg::ENABLE_ON);

  // ****************************************
  // Conversion input and formatting
  // ****************************************
  bfa_pkg::bfa_conv_t conv;
  bfa_pkg::bfa_word_t fmt_word;

  always_comb begin
    conv            = '0;
    conv.valid      = CONV_VALID;
    conv.channel    = CONV_CHANNEL;
    conv.data_valid = CONV_DATA_VALID;
    conv.result     = CONV_RESULT;
  end

  bfa_word_fmt u_fmt (
    .clk      (MCLK),
    .rst      (RESET),
    .conv     (conv),
    .layout   (layout_reg),
    .word_out (fmt_word)
  );

  // ****************************************
  // Fill count
  // ****************************************
  logic [4:0] fill_reg;

  // Saturating so a full buffer reads 16 and never wraps back to 0.
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      fill_reg <= '0;
    end else if (clear_all) begin
      fill_reg <= '0;
    end else if (CONV_VALID && fill_reg < 5'(FILL_DEPTH)) begin
      fill_reg <= fill_reg + 5'h01;
    end
  end

  // ****************************************
  // Accumulator
  // ****************************************
  logic [15:0] sum_reg [2];
  logic [3:0]  acc_cnt_reg;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sum
      always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
          sum_reg[g] <= '0;
        end else if (clear_all) begin
          sum_reg[g] <= '0;
        end else if (CONV_VALID && acc_on && (CONV_CHANNEL == 1'(g))) begin
          sum_reg[g] <= sum_reg[g] + {4'h0, CONV_RESULT};
        end
      end
    end
  endgenerate

  // Counts completed accumulations and wraps at its 4-bit width.
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      acc_cnt_reg <= '0;
    end else if (clear_all) begin
      acc_cnt_reg <= '0;
    end else if (CONV_VALID && acc_on) begin
      acc_cnt_reg <= acc_cnt_reg + 4'h1;
    end
  end

  // ****************************************
  // Read mux and acknowledge
  // ****************************************
  logic [7:0] rd_byte;

  always_comb begin
    case (idx)
      bfa_pkg::IDX_FILL_LEVEL[5:0]: rd_byte = {3'h0, fill_reg};
      bfa_pkg::IDX_SUM_STATUS[5:0]: rd_byte = {4'h0, acc_cnt_reg};
      bfa_pkg::IDX_SUM0_LOW[5:0]:   rd_byte = sum_reg[0][7:0];
      bfa_pkg::IDX_SUM0_HIGH[5:0]:  rd_byte = sum_reg[0][15:8];
      bfa_pkg::IDX_SUM1_LOW[5:0]:   rd_byte = sum_reg[1][7:0];
      bfa_pkg::IDX_SUM1_HIGH[5:0]:  rd_byte = sum_reg[1][15:8];
      bfa_pkg::IDX_LAYOUT_CFG[5:0]: rd_byte = {6'h00, layout_reg};
      bfa_pkg::IDX_SUM_ENABLE[5:0]: rd_byte = {4'h0, enable_reg};
      default:                      rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= req;
      if (req && !WB_WE_I) begin
        WB_DAT_O <= {24'h000000, rd_byte};
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      FILL_COUNT <= '0;
      ACC_ACTIVE <= 1'b0;
    end else begin
      FILL_COUNT <= fill_reg;
      ACC_ACTIVE <= acc_on;
    end
  end

  assign BUF_WORD_VALID = fmt_word.valid;
  assign BUF_WORD       = fmt_word.word;

endmodule

// file: bfa_regs_sva.sv
// Concurrent checks on the ports of the register bank.
`timescale 1ns/1ps
module bfa_regs_sva #(
  parameter int FILL_DEPTH = 16
) (
  // Watched ports
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        CONV_VALID,
  input wire logic [11:0] CONV_RESULT,
  input wire logic        BUF_WORD_VALID,
  input wire logic [15:0] BUF_WORD,
  input wire logic [4:0]  FILL_COUNT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence s_pulse; ##1 WB_ACK_O ##1 !WB_ACK_O; endsequence
  a_ack_pulse: assert property (s_req |-> s_pulse)
    else $error("ack pulse");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("stray ack");
  a_ack_idle: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("idle ack");
  a_read_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper bits");
  a_word_strobe: assert property (BUF_WORD_VALID == $past(CONV_VALID))
    else $error("word strobe");
  a_word_result: assert property (BUF_WORD_VALID |-> BUF_WORD[15:4] == $past(CONV_RESULT))
    else $error("word result");
  a_fill_max: assert property (FILL_COUNT <= FILL_DEPTH)
    else $error("fill max");
  // A rise of the count is only legal as one step caused by a conversion.
  a_fill_step: assert property (FILL_COUNT > $past(FILL_COUNT) |->
    FILL_COUNT == $past(FILL_COUNT) + 5'h1 && $past(CONV_VALID, 2))
    else $error("fill step");
endmodule

bind bfa_regs bfa_regs_sva #(.FILL_DEPTH(FILL_DEPTH)) u_sva (.MCLK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_DAT_O,
  .WB_ACK_O, .CONV_VALID, .CONV_RESULT, .BUF_WORD_VALID, .BUF_WORD, .FILL_COUNT);

// file: bfa_regs_tb.sv
// Self-checking bench for the buffer format and accumulator register bank.
`timescale 1ns/1ps
module bfa_regs_tb;
  logic        MCLK = 1'h0, RESET = 1'h1, cyc = 1'h0, we = 1'h0, cv = 1'h0, ch = 1'h0, dv = 1'h0;
  logic        ack, wv, act;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dato;
  logic [11:0] res = 12'h000, r;
  logic [15:0] word, s0 = 16'h0, s1 = 16'h0;
  logic [4:0]  fill;
  logic [3:0]  ec = 4'h0;
  logic [7:0]  ri [8] = '{8'h01, 8'h02, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h28, 8'h30};
  logic [3:0]  lo [4] = '{4'h0, 4'h2, 4'h1, 4'h0};
  int          fail_count = 0, checks_done = 0, n;

  bfa_regs #(.FILL_DEPTH(16)) uut (.MCLK(MCLK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK_O(ack), .CONV_VALID(cv),
    .CONV_CHANNEL(ch), .CONV_DATA_VALID(dv), .CONV_RESULT(res), .BUF_WORD_VALID(wv), .BUF_WORD(word),
    .FILL_COUNT(fill), .ACC_ACTIVE(act));

  initial begin
    forever #50 MCLK = ~MCLK;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Strobe and cycle share one net; the request holds until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge MCLK);
    cyc  <= 1'h1;
    we   <= w;
    adr  <= {i[5:0], 2'h0};
    wdat <= {24'h0, d};
    do @(posedge MCLK); while (ack !== 1'h1);
    rdat = dato;
    cyc  <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    wb(1'h0, i, 8'h00);
    chk($sformatf("reg%h", i), {24'h0, e}, rdat);
  endtask

  task automatic cnv(input logic c, input logic v, input logic [11:0] x);
    @(posedge MCLK);
    cv  <= 1'h1;
    ch  <= c;
    dv  <= v;
    res <= x;
    @(posedge MCLK);
    cv  <= 1'h0;
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge MCLK);
    RESET <= 1'h0;
    foreach (ri[k]) rd(ri[k], 8'h00);
    rd(8'h3F, 8'h00);
    wb(1'h1, 8'h08, 8'h5A);
    rd(8'h08, 8'h00);
    wb(1'h1, 8'h30, 8'h0F);
    rd(8'h30, 8'h0F);
    chk("active", 32'h1, {31'h0, act});
    // Eighteen conversions overrun the fill limit and wrap the accumulation count; the sums stay below 16 bits.
    for (n = 0; n < 18; n++) begin
      r = (n < 4) ? 12'hA50 + 12'(n) : 12'hFFF - 12'(n);
      if (n < 4)
        wb(1'h1, 8'h28, 8'(n));
      cnv(n[0], 1'h1, r);
      if (n < 4)
        chk("word", {16'h0, r, lo[n]}, {16'h0, word});
      chk("wvalid", 32'h1, {31'h0, wv});
      if (n[0])
        s1 = s1 + {4'h0, r};
      else
        s0 = s0 + {4'h0, r};
      ec = ec + 4'h1;
    end
    rd(8'h01, 8'h10);
    chk("fill", 32'h10, {27'h0, fill});
    rd(8'h02, {4'h0, ec});
    rd(8'h08, s0[7:0]);
    rd(8'h09, s0[15:8]);
    rd(8'h0A, s1[7:0]);
    rd(8'h0B, s1[15:8]);
    wb(1'h1, 8'h30, 8'h00);
    rd(8'h30, 8'h00);
    chk("active", 32'h0, {31'h0, act});
    cnv(1'h0, 1'h1, 12'h123);
    rd(8'h02, {4'h0, ec});
    rd(8'h08, s0[7:0]);
    rd(8'h01, 8'h10);
    for (n = 0; n < 3; n++) begin
      wb(1'h1, 8'h30, 8'h0F);
      cnv(1'h1, 1'h0, 12'h001);
      wb(1'h1, 8'h1E, 8'h01 << n);
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h00);
      rd(8'h0A, 8'h00);
      rd(8'h30, (n == 0) ? 8'h0F : 8'h00);
    end
    wb(1'h1, 8'h28, 8'hFF);
    rd(8'h28, 8'h03);
    // A short reset pulse in mid-run must clear the fill count like power-up does.
    cnv(1'h1, 1'h0, 12'h001);
    rd(8'h01, 8'h01);
    @(posedge MCLK);
    RESET <= 1'h1;
    @(posedge MCLK);
    RESET <= 1'h0;
    rd(8'h01, 8'h00);
    report_and_stop();
  end
endmodule

// file: bfa_word_fmt.sv
// Buffer word formatter that packs one conversion result into a 16-bit word.
`timescale 1ns/1ps
module bfa_word_fmt (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Conversion in, formatted word out
  input  wire bfa_pkg::bfa_conv_t conv,
  input  wire logic [1:0]        layout,
  output bfa_pkg::bfa_word_t     word_out
);

  logic [bfa_pkg::CHID_W-1:0] chid;
  logic [bfa_pkg::WORD_W-1:0] word_next;

  assign chid = {2'h0, conv.channel};

  always_comb begin
    case (layout)
      2'b00: word_next = {conv.result, 4'h0};
      2'b01: word_next = {conv.result, chid, 1'b0};
      2'b10: word_next = {conv.result, chid, conv.data_valid};
      2'b11: word_next = {conv.result, 4'h0};
      default: word_next = {conv.result, 4'h0};
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_out <= '0;
    end else begin
      word_out.valid <= conv.valid;
      if (conv.valid) begin
        word_out.word <= word_next;
      end
    end
  end

endmodule
